// File: pkg/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

  // ****************************************
  // Fuse encodings (a one bit means unprogrammed)
  // ****************************************
  localparam logic [3:0] SEL_EXT_CLOCK = 4'h0;
  localparam logic [3:0] SEL_RC_OSC = 4'h2;
  localparam logic [3:0] SEL_LF_XTAL_LO = 4'h6;
  localparam logic [3:0] SEL_LF_XTAL_HI = 4'h7;
  localparam logic [3:0] SEL_XTAL_LO = 4'h8;
  localparam logic [1:0] SUT_SHORT = 2'h0;
  localparam logic [1:0] SUT_MEDIUM = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RESERVED = 2'h3;

  // ****************************************
  // Shipped defaults
  // ****************************************
  localparam logic [3:0] DEFAULT_SOURCE = 4'h2;
  localparam logic [1:0] DEFAULT_SUT = 2'h2;
  localparam logic DEFAULT_DIV8 = 1'b0;
  localparam int DIV8_RATIO = 8;

  // ****************************************
  // Start-up counts
  // ****************************************
  localparam int RC_WAKE_CK = 6;
  localparam int RC_RESET_CK = 14;
  localparam int WDOG_SHORT_CYCLES = 4096;
  localparam int WDOG_LONG_CYCLES = 65536;

  // ****************************************
  // Clock source classes
  // ****************************************
  typedef enum logic [2:0] {
    SRC_RESERVED = 3'h0,
    SRC_XTAL = 3'h1,
    SRC_LF_XTAL = 3'h2,
    SRC_RC = 3'h3,
    SRC_EXT = 3'h4
  } source_t;

endpackage

// File: pkg/gate_if.sv
`timescale 1ns/1ns
interface gate_if;
  logic run_core;
  logic run_periph;
  logic run_adc;
  logic run_async;
  logic clk_en;
  logic core_en;
  logic periph_en;
  logic flash_en;
  logic adc_en;
  logic async_en;
  modport ctrl (output run_core, output run_periph, output run_adc, output run_async, output clk_en,
    input core_en, input periph_en, input flash_en, input adc_en, input async_en);
  modport gate (input run_core, input run_periph, input run_adc, input run_async, input clk_en,
    output core_en, output periph_en, output flash_en, output adc_en, output async_en);
endinterface

// File: core/wdog_timeout.sv
`timescale 1ns/1ns
module wdog_timeout #(
  parameter int SHORT_CYCLES = clk_ctrl_pkg::WDOG_SHORT_CYCLES,
  parameter int LONG_CYCLES = clk_ctrl_pkg::WDOG_LONG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wdog_tick_i,
  input wire logic start_i,
  input wire logic [1:0] sut_i,
  output logic done_o
);

  // ****************************************
  // Real-time count on watchdog oscillator ticks
  // ****************************************
  logic [16:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (start_i) begin
      done_nxt = 1'b0;
      case (sut_i) // R05
        clk_ctrl_pkg::SUT_MEDIUM: cnt_nxt = 17'(SHORT_CYCLES);
        clk_ctrl_pkg::SUT_LONG: cnt_nxt = 17'(LONG_CYCLES);
        default: cnt_nxt = 17'h0;
      endcase
      if (sut_i != clk_ctrl_pkg::SUT_MEDIUM && sut_i != clk_ctrl_pkg::SUT_LONG) begin
        done_nxt = 1'b1;
      end
    end else if (!done_r && wdog_tick_i) begin // R04 R09
      cnt_nxt = cnt_r - 17'h1;
      if (cnt_r == 17'h1) begin
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 17'h0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

  wdog_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    start_i && sut_i == clk_ctrl_pkg::SUT_LONG |=> cnt_r == 17'(LONG_CYCLES) && !done_r)
    else $error("Watchdog count not loaded with long time-out.");

endmodule

// File: core/clock_gate.sv
`timescale 1ns/1ns
module clock_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  gate_if.gate g
);

  // ****************************************
  // Domain enables, registered so consumers see glitch-free strobes
  // ****************************************
  logic core_r, core_nxt;
  logic periph_r, periph_nxt;
  logic flash_r, flash_nxt;
  logic adc_r, adc_nxt;
  logic async_r, async_nxt;

  always_comb begin
    core_nxt = g.clk_en && g.run_core; // R11
    flash_nxt = g.clk_en && g.run_core; // R14
    periph_nxt = g.clk_en && g.run_periph; // R12 R17
    adc_nxt = g.clk_en && g.run_adc; // R16
    async_nxt = g.run_async; // R15
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_r <= 1'b0;
      periph_r <= 1'b0;
      flash_r <= 1'b0;
      adc_r <= 1'b0;
      async_r <= 1'b0;
    end else begin
      core_r <= core_nxt;
      periph_r <= periph_nxt;
      flash_r <= flash_nxt;
      adc_r <= adc_nxt;
      async_r <= async_nxt;
    end
  end

  assign g.core_en = core_r;
  assign g.periph_en = periph_r;
  assign g.flash_en = flash_r;
  assign g.adc_en = adc_r;
  assign g.async_en = async_r;

  flash_core_a: assert property (@(posedge clk_i) disable iff (rst_i) flash_r == core_r) // R14
    else $error("Program memory enable differs from core enable.");

endmodule

// File: core/clock_source_startup_control.sv
`timescale 1ns/1ns
// How it works
// [R01] Four fuse bits select crystal, low-frequency crystal, RC, external, or reserved.
// [R02] A fuse bit at one is unprogrammed; zero is programmed.
// [R03] Wake from deep sleep counts selected-clock cycles before core runs again.
// [R04] Reset start adds a real-time delay timed by watchdog oscillator ticks.
// [R05] Reset time-out is 4096 or 65536 watchdog ticks by start-up setting.
// [R06] Shipped defaults: RC source, longest start-up, divide-by-eight programmed.
// [R07] Reset loads the factory calibration byte into the RC calibration value.
// [R08] Software may overwrite the calibration value; it drives the RC trim.
// [R09] Watchdog oscillator keeps timing watchdog and reset time-out with RC clock.
// [R10] RC source: wake 6 CK; reset 14 CK plus 0, 4.1 or 65 ms.
// [R11] Core clock enable feeds register file, status and stack storage.
// [R12] Peripheral clock enable may be gated; async interrupt detect stays live.
// [R13] Serial unit start detection stays armed while the peripheral clock halts.
// [R14] Program memory clock follows the core clock.
// [R15] Asynchronous timer domain keeps running during sleep.
// [R16] Converter domain may run while core and peripheral clocks halt.
// [R17] Sleep selection halts unused domains individually.
// [R18] All derived domains stay gated until both start-up counts expire; the asynchronous timer domain follows async_run_i and is not gated.
module clock_source_startup_control #(
  parameter int WDOG_SHORT = clk_ctrl_pkg::WDOG_SHORT_CYCLES,
  parameter int WDOG_LONG = clk_ctrl_pkg::WDOG_LONG_CYCLES,
  parameter logic [7:0] FACTORY_CAL = 8'h80
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fuses and oscillator ticks
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic divide_by_eight_fuse_i,
  input wire logic src_tick_i,
  input wire logic wdog_tick_i,
  // Sleep and calibration control
  input wire logic deep_sleep_i,
  input wire logic core_run_i,
  input wire logic periph_run_i,
  input wire logic adc_run_i,
  input wire logic async_run_i,
  input wire logic cal_we_i,
  input wire logic [7:0] cal_wdata_i,
  // Status and clock enables
  output logic [7:0] rc_calibration_value_o,
  output logic [2:0] source_o,
  output logic div8_o,
  output logic exec_ok_o,
  output logic watchdog_timer_clk_o,
  output logic start_detect_async_o,
  output logic core_clock_o,
  output logic peripheral_clock_o,
  output logic program_memory_clock_o,
  output logic converter_clock_o,
  output logic async_timer_clock_o
);

  // ****************************************
  // Fuse decode
  // ****************************************
  function automatic clk_ctrl_pkg::source_t decode_src(input logic [3:0] f);
    if (f >= clk_ctrl_pkg::SEL_XTAL_LO) begin // R01
      decode_src = clk_ctrl_pkg::SRC_XTAL;
    end else if (f == clk_ctrl_pkg::SEL_LF_XTAL_LO || f == clk_ctrl_pkg::SEL_LF_XTAL_HI) begin
      decode_src = clk_ctrl_pkg::SRC_LF_XTAL;
    end else if (f == clk_ctrl_pkg::SEL_RC_OSC) begin
      decode_src = clk_ctrl_pkg::SRC_RC;
    end else if (f == clk_ctrl_pkg::SEL_EXT_CLOCK) begin
      decode_src = clk_ctrl_pkg::SRC_EXT;
    end else begin
      decode_src = clk_ctrl_pkg::SRC_RESERVED;
    end
  endfunction

  // Start-up source cycles; only the RC tables are modelled, others reuse them.
  function automatic logic [4:0] ck_count(input logic reset_start);
    ck_count = reset_start ? 5'(clk_ctrl_pkg::RC_RESET_CK) : 5'(clk_ctrl_pkg::RC_WAKE_CK); // R10
  endfunction

  // ****************************************
  // Start-up sequencer
  // ****************************************
  typedef enum logic [3:0] {
    ST_LATCH = 4'b0001,
    ST_CK = 4'b0010,
    ST_WDOG = 4'b0100,
    ST_RUN = 4'b1000
  } state_t;

  state_t state_r, state_nxt;
  logic [4:0] ck_r, ck_nxt;
  logic from_reset_r, from_reset_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic [1:0] sut_r, sut_nxt;
  logic div8_r, div8_nxt;
  logic [7:0] cal_r, cal_nxt;
  logic exec_r, exec_nxt;
  logic wd_start;
  logic wd_done;
  logic sleep_d_r;
  clk_ctrl_pkg::source_t src_r, src_nxt;

  always_comb begin
    state_nxt = state_r;
    ck_nxt = ck_r;
    from_reset_nxt = from_reset_r;
    sel_nxt = sel_r;
    sut_nxt = sut_r;
    div8_nxt = div8_r;
    cal_nxt = cal_r;
    src_nxt = src_r;
    wd_start = 1'b0;
    if (cal_we_i && state_r != ST_LATCH) begin
      cal_nxt = cal_wdata_i; // R08
    end
    case (state_r)
      ST_LATCH: begin
        sel_nxt = clock_source_select_fuses_i;
        sut_nxt = startup_time_fuses_i;
        div8_nxt = !divide_by_eight_fuse_i; // R02
        src_nxt = decode_src(clock_source_select_fuses_i);
        cal_nxt = FACTORY_CAL; // R07
        ck_nxt = ck_count(1'b1);
        from_reset_nxt = 1'b1;
        state_nxt = ST_CK;
      end
      ST_CK: begin
        if (src_tick_i) begin // R03
          if (ck_r <= 5'h1) begin
            ck_nxt = 5'h0;
            if (from_reset_r) begin
              wd_start = 1'b1; // R04
              state_nxt = ST_WDOG;
            end else begin
              state_nxt = ST_RUN;
            end
          end else begin
            ck_nxt = ck_r - 5'h1;
          end
        end
      end
      ST_WDOG: begin
        if (wd_done) begin // R18
          from_reset_nxt = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_d_r && !deep_sleep_i) begin
          ck_nxt = ck_count(1'b0);
          state_nxt = ST_CK;
        end
      end
      default: state_nxt = ST_LATCH;
    endcase
    exec_nxt = (state_nxt == ST_RUN) && !deep_sleep_i; // R03 R18
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_LATCH;
      ck_r <= 5'h0;
      from_reset_r <= 1'b1;
      sel_r <= clk_ctrl_pkg::DEFAULT_SOURCE; // R06
      sut_r <= clk_ctrl_pkg::DEFAULT_SUT;
      div8_r <= !clk_ctrl_pkg::DEFAULT_DIV8;
      cal_r <= 8'h00;
      src_r <= clk_ctrl_pkg::SRC_RC;
      exec_r <= 1'b0;
      sleep_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ck_r <= ck_nxt;
      from_reset_r <= from_reset_nxt;
      sel_r <= sel_nxt;
      sut_r <= sut_nxt;
      div8_r <= div8_nxt;
      cal_r <= cal_nxt;
      src_r <= src_nxt;
      exec_r <= exec_nxt;
      sleep_d_r <= deep_sleep_i;
    end
  end

  wdog_timeout #(
    .SHORT_CYCLES(WDOG_SHORT),
    .LONG_CYCLES(WDOG_LONG)
  ) u_wdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wdog_tick_i(wdog_tick_i),
    .start_i(wd_start),
    .sut_i(sut_r),
    .done_o(wd_done)
  );

  // ****************************************
  // Domain gating
  // ****************************************
  gate_if g();

  // Start-up gating follows the run state, not the execute flag, so the converter
  // domain keeps its clock while deep sleep halts the core.
  assign g.clk_en = (state_r == ST_RUN); // R18
  assign g.run_core = core_run_i && !deep_sleep_i; // R17
  assign g.run_periph = periph_run_i && !deep_sleep_i;
  assign g.run_adc = adc_run_i; // R16
  assign g.run_async = async_run_i; // R15

  clock_gate u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .g(g)
  );

  logic wdclk_r, wdclk_nxt;
  logic start_async_r, start_async_nxt;

  always_comb begin
    wdclk_nxt = wdog_tick_i; // R09
    start_async_nxt = !g.periph_en; // R12 R13
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdclk_r <= 1'b0;
      start_async_r <= 1'b1;
    end else begin
      wdclk_r <= wdclk_nxt;
      start_async_r <= start_async_nxt;
    end
  end

  assign rc_calibration_value_o = cal_r;
  assign source_o = src_r;
  assign div8_o = div8_r;
  assign exec_ok_o = exec_r;
  assign watchdog_timer_clk_o = wdclk_r;
  assign start_detect_async_o = start_async_r;
  assign core_clock_o = g.core_en;
  assign peripheral_clock_o = g.periph_en;
  assign program_memory_clock_o = g.flash_en;
  assign converter_clock_o = g.adc_en;
  assign async_timer_clock_o = g.async_en;

  // ****************************************
  // Checks
  // ****************************************
  cal_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    state_r == ST_LATCH |=> cal_r == FACTORY_CAL)
    else $error("Calibration byte not loaded at reset.");
  cal_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R08
    cal_we_i && state_r == ST_RUN |=> cal_r == $past(cal_wdata_i))
    else $error("Calibration write not applied.");
  gated_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    state_r != ST_RUN |=> !core_clock_o)
    else $error("Core clock ran during start-up.");
  wdog_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    state_r == ST_WDOG && !wd_done |=> state_r != ST_RUN)
    else $error("Left reset delay before time-out.");
  wake_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    state_r == ST_RUN && sleep_d_r && !deep_sleep_i |=> state_r == ST_CK && ck_r == 5'h6)
    else $error("Wake count not six cycles.");
  fuse_sense_a: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    state_r == ST_LATCH |=> div8_r == !$past(divide_by_eight_fuse_i))
    else $error("Divide fuse sense inverted.");
  decode_rc_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    state_r == ST_LATCH && clock_source_select_fuses_i == 4'h2 |=> src_r == clk_ctrl_pkg::SRC_RC)
    else $error("RC selection misdecoded.");
  no_exec_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    deep_sleep_i |=> !exec_r)
    else $error("Execution allowed in deep sleep.");
  reset_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    state_r == ST_LATCH |=> state_r == ST_CK && ck_r == 5'(clk_ctrl_pkg::RC_RESET_CK))
    else $error("Reset count not fourteen cycles.");
  tick_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    state_r == ST_CK && !src_tick_i |=> state_r == ST_CK)
    else $error("Start-up count moved without a source tick.");
  wake_direct_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    state_r == ST_CK && !from_reset_r |=> state_r != ST_WDOG)
    else $error("Wake start-up took the reset delay.");
  wdog_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    state_r == ST_CK && src_tick_i && ck_r <= 5'h1 && from_reset_r |=> state_r == ST_WDOG)
    else $error("Reset start skipped the real-time delay.");
  exec_state_a: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    exec_ok_o |-> state_r == ST_RUN)
    else $error("Execution allowed outside the run state.");
  fuse_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    state_r != ST_LATCH |=> $stable(sel_r) && $stable(sut_r))
    else $error("Latched fuse settings changed after start.");
  converter_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    state_r == ST_RUN && adc_run_i |=> converter_clock_o)
    else $error("Converter clock halted while requested.");
  async_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    async_run_i |=> async_timer_clock_o)
    else $error("Asynchronous timer clock halted while requested.");
  wdog_clock_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    wdog_tick_i |=> watchdog_timer_clk_o)
    else $error("Watchdog timer clock missed a tick.");
  start_detect_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    !peripheral_clock_o |=> start_detect_async_o)
    else $error("Start detection not armed while peripheral clock halts.");
  core_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    deep_sleep_i |=> !core_clock_o && !peripheral_clock_o)
    else $error("Core or peripheral clock ran in deep sleep.");

endmodule

// File: testbench/clock_consumer_model.sv
`timescale 1ns/1ns
module clock_consumer_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Clock enables from the block
  input wire logic core_clock_i,
  input wire logic program_memory_clock_i,
  // Activity counts
  output logic [15:0] core_cycles_o,
  output logic [15:0] split_cycles_o
);
  // A core cycle is only work done when its enable is high, so any count before
  // start-up ends means code ran on an unstable clock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_cycles_o <= 16'h0000;
      split_cycles_o <= 16'h0000;
    end else begin
      if (core_clock_i) begin
        core_cycles_o <= core_cycles_o + 16'h0001;
      end
      if (core_clock_i != program_memory_clock_i) begin
        split_cycles_o <= split_cycles_o + 16'h0001;
      end
    end
  end
endmodule

// File: testbench/clock_source_startup_control_tb.sv
`timescale 1ns/1ns
module clock_source_startup_control_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] sel = 4'h2;
  logic [1:0] startup_time_fuses = 2'h2;
  logic div8f = 1'b0;
  logic src_tick = 1'b0;
  logic wdog_tick = 1'b0;
  logic deep_sleep = 1'b0;
  logic core_run = 1'b1;
  logic periph_run = 1'b1;
  logic adc_run = 1'b1;
  logic async_run = 1'b1;
  logic cal_we = 1'b0;
  logic [7:0] cal_wdata = 8'h00;
  logic [7:0] cal;
  logic [2:0] source;
  logic div8, exec_ok, wdt_clk, start_det, core_en, periph_en, flash_en, adc_en, async_en;
  logic [15:0] core_cycles, split_cycles;
  int num_errors = 0;
  int n_checks = 0;

  always #10 clk_i = ~clk_i;

  clock_source_startup_control #(.WDOG_SHORT(4), .WDOG_LONG(8)) i_clock_source_startup_control (
    .clk_i(clk_i), .rst_i(rst_i), .clock_source_select_fuses_i(sel), .startup_time_fuses_i(startup_time_fuses),
    .divide_by_eight_fuse_i(div8f), .src_tick_i(src_tick), .wdog_tick_i(wdog_tick),
    .deep_sleep_i(deep_sleep), .core_run_i(core_run), .periph_run_i(periph_run), .adc_run_i(adc_run),
    .async_run_i(async_run), .cal_we_i(cal_we), .cal_wdata_i(cal_wdata), .rc_calibration_value_o(cal),
    .source_o(source), .div8_o(div8), .exec_ok_o(exec_ok), .watchdog_timer_clk_o(wdt_clk),
    .start_detect_async_o(start_det), .core_clock_o(core_en), .peripheral_clock_o(periph_en),
    .program_memory_clock_o(flash_en), .converter_clock_o(adc_en), .async_timer_clock_o(async_en));

  clock_consumer_model i_clock_consumer_model (
    .clk_i(clk_i), .rst_i(rst_i), .core_clock_i(core_en), .program_memory_clock_i(flash_en),
    .core_cycles_o(core_cycles), .split_cycles_o(split_cycles));

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic pulse(input bit wdog, input int n);
    repeat (n) begin
      @(negedge clk_i);
      if (wdog) wdog_tick = 1'b1;
      else src_tick = 1'b1;
      @(negedge clk_i);
      wdog_tick = 1'b0;
      src_tick = 1'b0;
    end
  endtask

  // The bound covers the run-state hop plus its registered status flag.
  task automatic wait_exec();
    for (int i = 0; i < 6 && exec_ok !== 1'b1; i++) @(negedge clk_i);
  endtask

  task automatic do_reset(input logic [3:0] s, input logic [1:0] u, input logic d);
    @(negedge clk_i);
    rst_i = 1'b1;
    sel = s;
    startup_time_fuses = u;
    div8f = d;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
  endtask

  task automatic boot(input logic [1:0] u, input int nw);
    do_reset(4'h2, u, 1'b0);
    pulse(1'b0, 13);
    pulse(1'b1, 2);
    repeat (4) @(negedge clk_i);
    check(exec_ok === 1'b0, "run before source count");
    pulse(1'b0, 1);
    if (nw > 0) begin
      pulse(1'b1, nw - 1);
      repeat (4) @(negedge clk_i);
      check(exec_ok === 1'b0 && core_cycles === 16'h0000, "run before time-out");
      pulse(1'b1, 1);
    end
    wait_exec();
    check(exec_ok === 1'b1, "no run after start-up");
    repeat (2) @(negedge clk_i);
    check(core_en === 1'b1 && flash_en === 1'b1, "core not enabled");
    check(cal === 8'h80, "factory calibration not loaded");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults();
    boot(clk_ctrl_pkg::DEFAULT_SUT, 8);
    check(source === 3'h3 && div8 === 1'b1, "default source or prescale wrong");
    boot(2'h1, 4);
    boot(2'h0, 0);
    boot(2'h3, 0);
  endtask

  task automatic t_decode();
    logic [3:0] codes [10] = '{4'hF, 4'h8, 4'h7, 4'h6, 4'h2, 4'h0, 4'h3, 4'h1, 4'h5, 4'h4};
    logic [2:0] exp [10] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0};
    for (int i = 0; i < 10; i++) begin
      do_reset(codes[i], 2'h0, codes[i][0]);
      repeat (3) @(negedge clk_i);
      check(source === exp[i], "source class wrong");
      check(div8 === ~codes[i][0], "prescale fuse polarity wrong");
    end
  endtask

  task automatic t_wake();
    deep_sleep = 1'b1;
    repeat (4) @(negedge clk_i);
    check(core_en === 1'b0, "core runs in deep sleep");
    check(adc_en === 1'b1 && async_en === 1'b1, "converter or timer halted");
    deep_sleep = 1'b0;
    pulse(1'b0, 5);
    repeat (3) @(negedge clk_i);
    check(exec_ok === 1'b0 && core_en === 1'b0, "wake too early");
    pulse(1'b0, 1);
    wait_exec();
    check(exec_ok === 1'b1, "no wake after six cycles");
  endtask

  task automatic t_cal();
    @(negedge clk_i);
    cal_we = 1'b1;
    cal_wdata = 8'h3C;
    @(negedge clk_i);
    cal_we = 1'b0;
    check(cal === 8'h3C, "calibration write lost");
  endtask

  task automatic t_domains();
    core_run = 1'b0;
    repeat (3) @(negedge clk_i);
    check(core_en === 1'b0 && flash_en === 1'b0 && periph_en === 1'b1, "core gating wrong");
    core_run = 1'b1;
    periph_run = 1'b0;
    repeat (3) @(negedge clk_i);
    check(periph_en === 1'b0 && start_det === 1'b1 && core_en === 1'b1, "peripheral gating wrong");
    periph_run = 1'b1;
    adc_run = 1'b0;
    async_run = 1'b0;
    repeat (3) @(negedge clk_i);
    check(adc_en === 1'b0 && async_en === 1'b0 && periph_en === 1'b1, "domain halt wrong");
    check(start_det === 1'b0, "async detect armed while clocked");
    adc_run = 1'b1;
    async_run = 1'b1;
    @(negedge clk_i);
    wdog_tick = 1'b1;
    @(negedge clk_i);
    wdog_tick = 1'b0;
    check(wdt_clk === 1'b1, "watchdog clock missing");
    @(negedge clk_i);
    check(wdt_clk === 1'b0, "watchdog clock stuck");
  endtask

  task automatic end_of_test();
    $display("Checks: %0d, errors: %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    t_decode();
    t_defaults();
    t_wake();
    t_cal();
    t_domains();
    check(split_cycles === 16'h0000, "memory clock split from core");
    end_of_test();
  end

  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
